// [hw/exec_alu.sv]
`timescale 1ns/1ps

module exec_alu (
  // Instruction
  input exec_pkg::instr_t instr,
  // Operands
  input wire logic [7:0] acc,
  input wire logic [7:0] fdata,
  // Result
  output exec_pkg::alu_out_t res
);
  import exec_pkg::*;

  // ----------------------------------------------------------------
  // Result, flags and destination
  // ----------------------------------------------------------------
  always_comb begin
    res = '0;
    res.to_file = instr.operand[TARGET_BIT];
    case (instr.op)
      OP_OR_LITERAL_INTO_ACCUMULATOR: begin
        res.result = acc | instr.operand[7:0];
        res.to_file = 1'b0;
      end
      OP_INCREMENT_FILE_REGISTER: begin
        res.result = fdata + 8'h01;
      end
      OP_OR_ACCUMULATOR_WITH_FILE: begin
        res.result = acc | fdata;
      end
      OP_SHIFT_LEFT_FILE: begin
        res.result = {fdata[6:0], 1'b0};
        res.shift_out = fdata[7];
        res.touches_shift = 1'b1;
      end
      default: begin
        res.to_file = 1'b0;
      end
    endcase
    res.null_flag = (res.result == 8'h00);
  end

endmodule // exec_alu

// [hw/exec_core.sv]
// Overview of operation
// - Jump loads literal into PC bits 10:0
// - Jump takes PC bits 14:11 from latch 6:3
// - Jump takes two cycles, flags untouched
// - OR literal into accumulator, update null flag
// - Increment file register to chosen destination
// - OR accumulator with file register
// - Shift left, bit 7 to shift-out flag
// - Target bit picks accumulator or file
// - File address seven bits, target one bit
`timescale 1ns/1ps

module exec_core #(
  parameter int unsigned INSTR_DIV_P = exec_pkg::INSTR_DIV,
  parameter int unsigned FILE_DEPTH = 128
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // APB slave
  input exec_pkg::apb_req_t apb_req,
  output exec_pkg::apb_rsp_t apb_rsp,
  // Core state
  output logic [14:0] program_counter,
  output logic [7:0] accumulator,
  output logic exec_busy
);
  import exec_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  generate
    if (INSTR_DIV_P < 1 || INSTR_DIV_P > 255) begin : g_bad_div
      $error("INSTR_DIV_P must be 1 to 255");
    end
    if (FILE_DEPTH < 1 || FILE_DEPTH > 128) begin : g_bad_depth
      $error("FILE_DEPTH must be 1 to 128");
    end
  endgenerate

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXECUTE = 3'b010,
    ST_JUMP_FLUSH = 3'b100
  } state_t;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  state_t state_q;
  instr_t instr_q;
  logic [7:0] acc_q;
  logic [14:0] pc_q;
  logic [6:0] latch_q;
  logic [6:0] faddr_q;
  logic shift_out_q;
  logic null_q;
  logic [7:0] div_q;
  logic [31:0] prdata_q;
  logic [7:0] file_q [FILE_DEPTH];

  logic cyc_en;
  logic busy;
  logic setup;
  logic access;
  logic mapped;
  logic wr_stall;
  logic wr_done;
  logic [6:0] exec_addr;
  logic [7:0] exec_fdata;
  logic [7:0] host_fdata;
  logic retire;
  alu_out_t alu;

  // ----------------------------------------------------------------
  // Instruction cycle divider
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst || div_q == 8'(INSTR_DIV_P - 1)) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  assign cyc_en = (div_q == 8'(INSTR_DIV_P - 1));
  assign busy = (state_q != ST_IDLE);
  assign exec_busy = busy;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign setup = apb_req.psel && !apb_req.penable;
  assign access = apb_req.psel && apb_req.penable;
  assign mapped = (apb_req.paddr[1:0] == 2'b00) && (apb_req.paddr <= OFS_STATE);
  assign wr_stall = apb_req.pwrite && mapped && busy;  // Mapped writes wait for idle core
  assign wr_done = access && apb_req.pwrite && mapped && !busy;
  assign apb_rsp.pready = !wr_stall;
  assign apb_rsp.pslverr = access && !mapped;
  assign apb_rsp.prdata = prdata_q;

  // File reads for the bus and the executing instruction
  assign exec_addr = instr_q.operand[FADDR_W-1:0];
  assign exec_fdata = (32'(exec_addr) < FILE_DEPTH) ? file_q[exec_addr] : 8'h00;
  assign host_fdata = (32'(faddr_q) < FILE_DEPTH) ? file_q[faddr_q] : 8'h00;

  // Read data captured during setup
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata_q <= 32'h00000000;
    end else if (setup) begin
      case (apb_req.paddr)
        OFS_INSTR: prdata_q <= {17'h00000, instr_q};
        OFS_ACC: prdata_q <= {24'h000000, acc_q};
        OFS_STATUS: prdata_q <= {30'h00000000, null_q, shift_out_q};
        OFS_PC: prdata_q <= {17'h00000, pc_q};
        OFS_LATCH: prdata_q <= {25'h0000000, latch_q};
        OFS_FADDR: prdata_q <= {25'h0000000, faddr_q};
        OFS_FDATA: prdata_q <= {24'h000000, host_fdata};
        OFS_STATE: prdata_q <= {31'h00000000, busy};
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Execution
  // ----------------------------------------------------------------
  exec_alu u_exec_alu (
    .instr(instr_q),
    .acc(acc_q),
    .fdata(exec_fdata),
    .res(alu)
  );

  assign retire = (state_q == ST_EXECUTE) && cyc_en;

  // Sequencer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (wr_done && apb_req.paddr == OFS_INSTR) begin
            state_q <= ST_EXECUTE;
          end
        end
        ST_EXECUTE: begin
          if (cyc_en) begin
            if (instr_q.op == OP_UNCONDITIONAL_JUMP) begin
              state_q <= ST_JUMP_FLUSH;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_JUMP_FLUSH: begin
          if (cyc_en) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Instruction register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      instr_q <= INSTR_RST;
    end else if (wr_done && apb_req.paddr == OFS_INSTR) begin
      instr_q <= instr_t'(apb_req.pwdata[14:0]);
    end
  end

  // Program counter
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pc_q <= PC_RST;
    end else if (retire) begin
      if (instr_q.op == OP_UNCONDITIONAL_JUMP) begin
        pc_q[JUMP_LIT_W-1:0] <= instr_q.operand;
        pc_q[PC_W-1:JUMP_LIT_W] <= latch_q[LATCH_HI_MSB:LATCH_HI_LSB];
      end else begin
        pc_q <= pc_q + 15'h0001;
      end
    end else if (wr_done && apb_req.paddr == OFS_PC) begin
      pc_q <= apb_req.pwdata[14:0];
    end
  end

  // High address latch
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      latch_q <= LATCH_RST;
    end else if (wr_done && apb_req.paddr == OFS_LATCH) begin
      latch_q <= apb_req.pwdata[6:0];
    end
  end

  // Accumulator
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      acc_q <= ACC_RST;
    end else if (retire && instr_q.op != OP_UNCONDITIONAL_JUMP && instr_q.op != OP_NONE
                 && !alu.to_file) begin
      acc_q <= alu.result;
    end else if (wr_done && apb_req.paddr == OFS_ACC) begin
      acc_q <= apb_req.pwdata[7:0];
    end
  end

  // Result flags; execution wins over a bus write
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      shift_out_q <= 1'b0;
      null_q <= 1'b0;
    end else if (retire && instr_q.op != OP_UNCONDITIONAL_JUMP
                 && instr_q.op != OP_NONE) begin
      null_q <= alu.null_flag;
      if (alu.touches_shift) begin
        shift_out_q <= alu.shift_out;
      end
    end else if (wr_done && apb_req.paddr == OFS_STATUS) begin
      shift_out_q <= apb_req.pwdata[STAT_SHIFT_OUT_BIT];
      null_q <= apb_req.pwdata[STAT_NULL_BIT];
    end
  end

  // File address pointer for bus access
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      faddr_q <= FADDR_RST;
    end else if (wr_done && apb_req.paddr == OFS_FADDR) begin
      faddr_q <= apb_req.pwdata[6:0];
    end
  end

  // File registers
  always_ff @(posedge ref_clk) begin
    if (retire && alu.to_file && 32'(exec_addr) < FILE_DEPTH) begin
      file_q[exec_addr] <= alu.result;
    end else if (wr_done && apb_req.paddr == OFS_FDATA && 32'(faddr_q) < FILE_DEPTH) begin
      file_q[faddr_q] <= apb_req.pwdata[7:0];
    end
  end

  assign program_counter = pc_q;
  assign accumulator = acc_q;

endmodule // exec_core

// [hw/exec_pkg.sv]
package exec_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned INSTR_DIV = 4;          // Clocks per instruction cycle
  localparam int unsigned JUMP_CYCLES = 2;        // Instruction cycles of a jump

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PC = 8'h0C;
  localparam logic [7:0] OFS_LATCH = 8'h10;
  localparam logic [7:0] OFS_FADDR = 8'h14;
  localparam logic [7:0] OFS_FDATA = 8'h18;
  localparam logic [7:0] OFS_STATE = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int unsigned STAT_SHIFT_OUT_BIT = 0;
  localparam int unsigned STAT_NULL_BIT = 1;
  localparam int unsigned STATE_BUSY_BIT = 0;
  localparam int unsigned PC_W = 15;
  localparam int unsigned LATCH_W = 7;
  localparam int unsigned JUMP_LIT_W = 11;
  localparam int unsigned LATCH_HI_MSB = 6;
  localparam int unsigned LATCH_HI_LSB = 3;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned TARGET_BIT = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [14:0] PC_RST = 15'h0000;
  localparam logic [6:0] LATCH_RST = 7'h00;
  localparam logic [6:0] FADDR_RST = 7'h00;
  localparam logic [14:0] INSTR_RST = 15'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_UNCONDITIONAL_JUMP = 3'h1,
    OP_OR_LITERAL_INTO_ACCUMULATOR = 3'h2,
    OP_INCREMENT_FILE_REGISTER = 3'h3,
    OP_OR_ACCUMULATOR_WITH_FILE = 3'h4,
    OP_SHIFT_LEFT_FILE = 3'h5
  } op_t;

  typedef struct packed {
    op_t op;                        // [14:12]
    logic spare;                    // [11]
    logic [10:0] operand;           // [10:0]
  } instr_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic [7:0] result;
    logic shift_out;
    logic null_flag;
    logic touches_shift;
    logic to_file;
  } alu_out_t;

endpackage

// [testbench/branch_or_increment_shift_exec_test.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module branch_or_increment_shift_exec_test;
  import exec_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  apb_req_t apb_req = '0;
  apb_rsp_t apb_rsp;
  logic [14:0] program_counter;
  logic [7:0] accumulator;
  logic exec_busy;
  logic [31:0] rdat;
  logic rerr;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  // Clock and run limit
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  exec_core #(.INSTR_DIV_P(4), .FILE_DEPTH(128)) u_exec_core (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .program_counter(program_counter), .accumulator(accumulator), .exec_busy(exec_busy));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ------------------------------------------
  // Bus helpers
  // ------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    apb_req.psel <= 1'b1;
    apb_req.pwrite <= w;
    apb_req.paddr <= a;
    apb_req.pwdata <= d;
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    do @(posedge ref_clk); while (apb_rsp.pready !== 1'b1);
    rdat = apb_rsp.prdata;
    rerr = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask
  task automatic run(input logic [2:0] op, input logic [10:0] opnd);
    xfer(1'b1, OFS_INSTR, {17'h0, op, 1'b0, opnd});
    @(posedge ref_clk);
    do @(posedge ref_clk); while (exec_busy !== 1'b0);
  endtask
  task automatic setf(input logic [6:0] a, input logic [7:0] v);
    xfer(1'b1, OFS_FADDR, {25'h0, a});
    xfer(1'b1, OFS_FDATA, {24'h0, v});
  endtask
  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  task automatic t_or_literal();
    xfer(1'b1, OFS_ACC, 32'h50);
    run(OP_OR_LITERAL_INTO_ACCUMULATOR, 11'h0A5);
    `CHK(accumulator, 8'hF5)
    rchk(OFS_STATUS, 32'h0);
    rchk(OFS_PC, 32'h1);
    xfer(1'b1, OFS_ACC, 32'h0);
    run(OP_OR_LITERAL_INTO_ACCUMULATOR, 11'h000);
    rchk(OFS_STATUS, 32'h2);
  endtask
  task automatic t_increment();
    setf(7'h7F, 8'hFF);
    run(OP_INCREMENT_FILE_REGISTER, {4'h1, 7'h7F});
    rchk(OFS_FDATA, 32'h0);
    rchk(OFS_STATUS, 32'h2);
    run(OP_INCREMENT_FILE_REGISTER, {4'h0, 7'h7F});
    `CHK(accumulator, 8'h01)
    rchk(OFS_FDATA, 32'h0);
  endtask
  task automatic t_or_file();
    setf(7'h00, 8'hF0);
    xfer(1'b1, OFS_ACC, 32'h0F);
    run(OP_OR_ACCUMULATOR_WITH_FILE, {4'h0, 7'h00});
    `CHK(accumulator, 8'hFF)
    xfer(1'b1, OFS_INSTR, {17'h0, OP_OR_ACCUMULATOR_WITH_FILE, 1'b0, 4'h1, 7'h00});
    xfer(1'b1, OFS_ACC, 32'h33);
    rchk(OFS_FDATA, 32'hFF);
    `CHK(accumulator, 8'h33)
  endtask
  task automatic t_shift();
    setf(7'h40, 8'h81);
    run(OP_SHIFT_LEFT_FILE, {4'h1, 7'h40});
    rchk(OFS_FDATA, 32'h02);
    rchk(OFS_STATUS, 32'h1);
    setf(7'h40, 8'h80);
    run(OP_SHIFT_LEFT_FILE, {4'h0, 7'h40});
    `CHK(accumulator, 8'h00)
    rchk(OFS_STATUS, 32'h3);
  endtask
  task automatic t_jump();
    xfer(1'b1, OFS_LATCH, 32'h50);
    xfer(1'b1, OFS_STATUS, 32'h0);
    xfer(1'b1, OFS_ACC, 32'h5A);
    run(OP_UNCONDITIONAL_JUMP, 11'h523);
    rchk(OFS_PC, 32'h5523);
    rchk(OFS_STATUS, 32'h0);
    `CHK(accumulator, 8'h5A)
    xfer(1'b1, OFS_LATCH, 32'h7F);
    run(OP_UNCONDITIONAL_JUMP, 11'h7FF);
    rchk(OFS_PC, 32'h7FFF);
    `CHK(program_counter, 15'h7FFF)
    run(OP_NONE, 11'h7FF);
    `CHK(accumulator, 8'h5A)
    rchk(OFS_STATUS, 32'h0);
    xfer(1'b0, 8'h20, 32'h0);
    `CHK(rerr, 1'b1)
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_or_literal();
    t_increment();
    t_or_file();
    t_shift();
    t_jump();
    finish_test();
  end
endmodule // branch_or_increment_shift_exec_test

// [testbench/exec_core_sva.sv]
`timescale 1ns/1ps
// ------------------------------------------
// Checker on the core ports
// ------------------------------------------
module exec_core_sva #(
  parameter int unsigned INSTR_DIV_P = 4,
  parameter int unsigned FILE_DEPTH = 128
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Bus
  input exec_pkg::apb_req_t apb_req,
  input exec_pkg::apb_rsp_t apb_rsp,
  // Core state
  input wire logic [14:0] program_counter,
  input wire logic [7:0] accumulator,
  input wire logic exec_busy
);
  import exec_pkg::*;
  logic wr_t;
  logic rt;
  logic [14:0] ins_q;
  logic [14:0] pc_q;
  logic [7:0] acc_q;
  logic [6:0] lat_q;
  int unsigned cnt_q;
  // Taken write, and retire after a busy run
  assign wr_t = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;
  assign rt = !exec_busy && cnt_q != 32'h0;
  // Snapshot of state at each instruction write, and of the latch at each latch write
  always_ff @(posedge ref_clk) begin
    if (wr_t && apb_req.paddr == OFS_INSTR) begin
      ins_q <= apb_req.pwdata[14:0];
      pc_q <= program_counter;
      acc_q <= accumulator;
    end
    if (wr_t && apb_req.paddr == OFS_LATCH) begin
      lat_q <= apb_req.pwdata[6:0];
    end
  end
  // Length of the current busy run
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= exec_busy ? cnt_q + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  jump_low_bits_a: assert property (rt && ins_q[14:12] == 3'h1
    |-> program_counter[10:0] == ins_q[10:0]) else $error("jump low bits");
  jump_high_bits_a: assert property (rt && ins_q[14:12] == 3'h1
    |-> program_counter[14:11] == lat_q[6:3]) else $error("jump high bits");
  jump_length_a: assert property (rt && ins_q[14:12] == 3'h1
    |-> cnt_q > INSTR_DIV_P && cnt_q <= 2 * INSTR_DIV_P) else $error("jump length");
  jump_keeps_acc_a: assert property (rt && ins_q[14:12] == 3'h1
    |-> accumulator == acc_q) else $error("jump changed accumulator");
  or_literal_a: assert property (rt && ins_q[14:12] == 3'h2
    |-> accumulator == (acc_q | ins_q[7:0])) else $error("or literal result");
  file_target_a: assert property (rt && ins_q[14:12] > 3'h2 && ins_q[7]
    |-> accumulator == acc_q) else $error("file target hit accumulator");
  single_length_a: assert property (rt && ins_q[14:12] > 3'h1
    |-> cnt_q <= INSTR_DIV_P) else $error("single op too long");
  pc_step_a: assert property (rt && ins_q[14:12] > 3'h1
    |-> program_counter == pc_q + 15'h1) else $error("pc not advanced");
  busy_start_a: assert property (wr_t && apb_req.paddr == OFS_INSTR
    && apb_req.pwdata[14:12] inside {[3'h1:3'h5]} |=> exec_busy) else $error("busy missing");
  jump_seen_c: cover property (rt && ins_q[14:12] == 3'h1);
  or_seen_c: cover property (rt && ins_q[14:12] == 3'h2);
  stall_seen_c: cover property (apb_req.psel && apb_req.penable && !apb_rsp.pready);
endmodule // exec_core_sva

bind exec_core exec_core_sva #(.INSTR_DIV_P(INSTR_DIV_P), .FILE_DEPTH(FILE_DEPTH)) u_sva (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .program_counter(program_counter), .accumulator(accumulator), .exec_busy(exec_busy));
